// >>> shared/pas_consts.vh
// Constants for the PWM auto-shutdown block
`ifndef PAS_CONSTS_VH
`define PAS_CONSTS_VH
`define PAS_ADDR_CONTROL 12'h000
`define PAS_ADDR_IRQ_STATUS 12'h004
`define PAS_ADDR_IRQ_MASK 12'h008
`define PAS_ADDR_RESTART 12'h00C
`define PAS_CONTROL_RESET 8'h00
`define PAS_STATUS_BIT 7
`define PAS_SRC_HI 6
`define PAS_SRC_LO 4
`define PAS_AC_HI 3
`define PAS_AC_LO 2
`define PAS_BD_HI 1
`define PAS_BD_LO 0
`define PAS_SRC_COMP_ONE 0
`define PAS_SRC_COMP_TWO 1
`define PAS_SRC_PIN 2
`define PAS_STATE_LOW 2'h0
`define PAS_STATE_HIGH 2'h1
`define PAS_IRQ_EVENT 0
`define PAS_IRQ_RESTART 1
`define PAS_IRQ_WIDTH 2
`endif

// >>> sim/pas_fault_src.sv
// Fault pin and comparator model
`timescale 1ns/1ps
`default_nettype none
module pas_fault_src(
	input wire clk,
	input wire [2:0] want,
	output logic faultPinN = 1'b1,
	output logic comparatorOne = 1'b0,
	output logic comparatorTwo = 1'b0
);
	always @(posedge clk)
	begin
		comparatorOne <= want[0];
		comparatorTwo <= want[1];
		faultPinN <= !want[2];
	end
endmodule // pas_fault_src
`default_nettype wire

// >>> sim/pas_props.sv
// Checker for the auto-shutdown block
`timescale 1ns/1ps
`default_nettype none
module pas_props(
	input wire logic clk, rst, psel, penable, pwrite, pslverr, irq,
	input wire logic faultPinN, comparatorOne, comparatorTwo,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata, prdata,
	input wire logic [3:0] pwmIn, pwmEnable, pwmOut, pwmOe
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	reg [6:0] c;
	wire ev = c[4]&comparatorOne | c[5]&comparatorTwo | c[6]&!faultPinN;
	wire bad = paddr[11:4]!=0;
	wire wr = psel&penable&pwrite&!paddr;
	// Shadow of the control fields
	always @(posedge clk)
		if (rst) c <= 7'h00;
		else if (wr) c <= pwdata[6:0];
	sequence s_ev; ev[*8]; endsequence
	sequence s_rd; psel&&!penable&&!pwrite; endsequence
	property p_ac; ev&&pwmEnable[0] |->
		pwmOut[0]==(c[3:2]==2'h1)&&pwmOe[0]==!c[3]; endproperty
	a_ac: assert property(p_ac) else $error("pair ac state");
	property p_bd; ev&&pwmEnable[1] |->
		pwmOut[1]==(c[1:0]==2'h1)&&pwmOe[1]==!c[1]; endproperty
	a_bd: assert property(p_bd) else $error("pair bd state");
	property p_off; (((pwmOut^pwmIn)|pwmOe)&~pwmEnable)==0; endproperty
	a_off: assert property(p_off) else $error("disabled pin");
	property p_err; psel&&penable&&bad |-> pslverr; endproperty
	a_err: assert property(p_err) else $error("no error");
	property p_rd; s_rd ##0 bad |=> prdata==0; endproperty
	a_rd: assert property(p_rd) else $error("unmapped data");
	property p_rst; $fell(rst) |-> !irq&&prdata==0; endproperty
	a_rst: assert property(p_rst) else $error("reset state");
	property p_stat; s_ev ##0 s_rd ##0 !paddr |=> prdata[7]; endproperty
	a_stat: assert property(p_stat) else $error("status low");
	property p_sw; wr&&pwdata[7] |=>
		pwmOe==(pwmEnable&~{c[1],c[3],c[1],c[3]}); endproperty
	a_sw: assert property(p_sw) else $error("soft shutdown");
endmodule // pas_props
bind pas_auto_shutdown pas_props u_props(.*);
`default_nettype wire

// >>> sim/test_pas_auto_shutdown.sv
// Testbench for the auto-shutdown block
`timescale 1ns/1ps
`default_nettype none
module test_pas_auto_shutdown;
	logic clk=0, rst=1, psel=0, penable=0, pwrite=0, autoRestart=0, frc, e;
	logic [11:0] paddr=0;
	logic [31:0] pwdata=0, prdata, r, seed=32'hCF83D900;
	logic [3:0] pwmIn=0, pwmEnable=0, pwmOut, pwmOe;
	logic [2:0] f=0, sl;
	logic [7:0] ctl;
	wire fp, c1, c2, pready, pslverr, irq;
	integer error_cnt=0, samples_checked=0, cyc=0, i;
	always #5 clk=~clk;
	pas_fault_src src(.clk(clk), .want(f), .faultPinN(fp),
		.comparatorOne(c1), .comparatorTwo(c2));
	pas_auto_shutdown dut(.clk(clk), .clkEn(1'b1), .rst(rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.faultPinN(fp), .comparatorOne(c1), .comparatorTwo(c2),
		.pwmIn(pwmIn), .pwmEnable(pwmEnable), .autoRestart(autoRestart),
		.pwmOut(pwmOut), .pwmOe(pwmOe), .irq(irq));
	function [31:0] xs(input [31:0] x);
		x=x^(x<<13);
		x=x^(x>>17);
		xs=x^(x<<5);
	endfunction
	// Expected {oe,out} of the four pins
	function [7:0] ex(input b);
		integer j;
		logic [1:0] s;
		for(j=0;j<4;j++)
		begin
			s=j[0]?ctl[1:0]:ctl[3:2];
			ex[j]=b&pwmEnable[j]?s==2'h1:pwmIn[j];
			ex[j+4]=pwmEnable[j]&!(b&s[1]);
		end
	endfunction
	task chk(input [31:0] g, e);
		samples_checked++;
		if(g!==e)
		begin
			error_cnt++;
			$display("BAD %0t got %h want %h",$time,g,e);
		end
	endtask
	task bus(input w, input [11:0] a, input [31:0] d);
		@(posedge clk) {psel,pwrite,paddr,pwdata}<={1'b1,w,a,d};
		@(posedge clk) penable<=1;
		@(posedge clk);
		while(pready!==1'b1) @(posedge clk);
		r=prdata;
		e=pslverr;
		{psel,penable}<=2'h0;
	endtask
	task give_verdict;
		if(error_cnt==0&&samples_checked>0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	always @(posedge clk)
	begin
		cyc++;
		if(cyc>5000)
		begin
			error_cnt++;
			give_verdict;
		end
	end
	initial
	begin
		repeat(6) @(posedge clk);
		rst<=0;
		bus(0,0,0);
		chk(r,0);
		bus(0,12'h010,0);
		chk(r,0);
		chk(e,1);
		bus(1,8,1);
		for(i=0;i<24;i++)
		begin
			seed=xs(seed);
			sl=3'(i/3);
			ctl={1'b0,sl,seed[3:0]};
			pwmIn<=seed[11:8];
			pwmEnable<=seed[15:12];
			bus(1,0,ctl);
			bus(0,0,0);
			chk(r,ctl);
			f<=3'h1<<(i%3);
			frc=sl[i%3];
			@(posedge clk);
			@(negedge clk);
			chk({pwmOe,pwmOut},ex(frc));
			repeat(8) @(posedge clk);
			bus(0,0,0);
			chk({r[7],irq},{frc,frc});
			f<=0;
			repeat(8) @(posedge clk);
			@(negedge clk);
			chk({pwmOe,pwmOut},ex(frc));
			if(i[0])
				bus(1,0,ctl);
			else
			begin
				@(posedge clk) autoRestart<=1;
				@(posedge clk) autoRestart<=0;
			end
			bus(0,4,0);
			chk(r,{~i[0]&frc,frc});
			bus(1,4,3);
			@(negedge clk);
			chk({pwmOe,pwmOut,irq},{ex(0),1'b0});
		end
		bus(1,8,0);
		ctl=8'h05;
		bus(1,0,8'h85);
		@(negedge clk);
		chk({pwmOe,pwmOut,irq},{ex(1),1'b0});
		bus(0,4,0);
		chk(r,1);
		bus(1,8,1);
		@(negedge clk);
		chk(irq,1);
		give_verdict;
	end
endmodule // test_pas_auto_shutdown
`default_nettype wire

// >>> verilog/pas_auto_shutdown.v
// PWM auto-shutdown logic with APB control and interrupt
// Functional notes
// - Shutdown from pin, comparators, or software
// - Source select field picks enabled sources
// - Status bit shows outputs held shut
// - Status stays set until cleared or restart
// - Enabled outputs forced immediately on event
// - Pair A/C state: low, high, tri-state
// - Pair B/D state: low, high, tri-state
// - Control fields read/write, reset to zero
//
// The APB slave port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`include "pas_consts.vh"
`default_nettype none

module pas_auto_shutdown
(
	// Clock, enable and reset
	input wire clk,
	input wire clkEn,
	input wire rst,
	// APB slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	input wire [3:0] pstrb,
	output wire [31:0] prdata,
	output wire pready,
	output wire pslverr,
	// Fault sources
	input wire faultPinN,
	input wire comparatorOne,
	input wire comparatorTwo,
	// Modulated outputs and their enables from the PWM unit
	input wire [3:0] pwmIn,
	input wire [3:0] pwmEnable,
	// Auto-restart clear from the PWM unit
	input wire autoRestart,
	// Output pins a, b, c, d
	output wire [3:0] pwmOut,
	output wire [3:0] pwmOe,
	// Level interrupt
	output wire irq
);

	reg [2:0] sourceSelect;
	reg [1:0] pairAcState;
	reg [1:0] pairBdState;
	reg shutdownStatus;
	reg [`PAS_IRQ_WIDTH-1:0] irqStatus;
	reg [`PAS_IRQ_WIDTH-1:0] irqMask;
	reg [31:0] readData;
	reg [2:0] syncPin;
	reg [2:0] syncOne;
	reg [2:0] syncTwo;
	reg pinLowS;
	reg oneHighS;
	reg twoHighS;
	wire apbWrite;
	wire apbRead;
	wire addrOk;
	wire swSet;
	wire swClear;
	wire syncFault;
	wire rawFault;
	wire shutActive;
	wire [7:0] controlRead;
	wire [`PAS_IRQ_WIDTH-1:0] irqEvents;
	wire [`PAS_IRQ_WIDTH-1:0] irqClear;
	reg [3:0] next_pwmOut;
	reg [3:0] next_pwmOe;
	integer i;
	wire hitControl;
	wire hitIrqStatus;
	wire hitIrqMask;
	wire hitRestart;
	wire writeControl;
	wire writeIrqStatus;
	wire writeIrqMask;
	wire enOne;
	wire enTwo;
	wire enPin;
	wire faultEntry;
	wire restartClear;
	wire pairAcTri;
	wire pairAcLevel;
	wire pairBdTri;
	wire pairBdLevel;
	reg next_shutdownStatus;
	reg [`PAS_IRQ_WIDTH-1:0] next_irqStatus;
	reg [31:0] next_readData;

	assign apbWrite = psel & penable & pwrite & clkEn;
	assign apbRead = psel & ~pwrite;
	assign hitControl = (paddr == `PAS_ADDR_CONTROL);
	assign hitIrqStatus = (paddr == `PAS_ADDR_IRQ_STATUS);
	assign hitIrqMask = (paddr == `PAS_ADDR_IRQ_MASK);
	// Reserved word: no error, reads zero, writes dropped
	assign hitRestart = (paddr == `PAS_ADDR_RESTART);
	assign addrOk = hitControl | hitIrqStatus | hitIrqMask | hitRestart;

	// Only the low byte lane holds register bits
	assign writeControl = apbWrite & hitControl & pstrb[0];
	assign writeIrqStatus = apbWrite & hitIrqStatus & pstrb[0];
	assign writeIrqMask = apbWrite & hitIrqMask & pstrb[0];

	// Every access completes in its first access cycle
	assign pready = 1'b1;
	// Error only in the access phase of an unmapped word
	assign pslverr = psel & penable & ~addrOk;
	assign prdata = readData;

	// Three-stage synchronisers; a change counts when stages two and three agree
	// Fault pin idles high; stages preset so reset gives no false fault
	always @(posedge clk)
	begin
		if (rst)
		begin
			syncPin <= 3'h7;
			pinLowS <= 1'b0;
		end
		else if (clkEn)
		begin
			syncPin <= {syncPin[1:0], faultPinN};
			if (syncPin[1] == syncPin[2])
			begin
				pinLowS <= ~syncPin[2];
			end
		end
	end

	// Comparator one
	always @(posedge clk)
	begin
		if (rst)
		begin
			syncOne <= 3'h0;
			oneHighS <= 1'b0;
		end
		else if (clkEn)
		begin
			syncOne <= {syncOne[1:0], comparatorOne};
			if (syncOne[1] == syncOne[2])
			begin
				oneHighS <= syncOne[2];
			end
		end
	end

	// Comparator two
	always @(posedge clk)
	begin
		if (rst)
		begin
			syncTwo <= 3'h0;
			twoHighS <= 1'b0;
		end
		else if (clkEn)
		begin
			syncTwo <= {syncTwo[1:0], comparatorTwo};
			if (syncTwo[1] == syncTwo[2])
			begin
				twoHighS <= syncTwo[2];
			end
		end
	end

	// Source enables from the select field
	assign enOne = sourceSelect[`PAS_SRC_COMP_ONE];
	assign enTwo = sourceSelect[`PAS_SRC_COMP_TWO];
	assign enPin = sourceSelect[`PAS_SRC_PIN];

	// Synchronised fault, gated by the source select field
	assign syncFault = (enOne & oneHighS)
		| (enTwo & twoHighS)
		| (enPin & pinLowS);

	// Raw fault for the immediate pin override
	// Unsynchronised on purpose: pins follow a fault with no clock edge
	assign rawFault = (enOne & comparatorOne)
		| (enTwo & comparatorTwo)
		| (enPin & ~faultPinN);

	assign swSet = writeControl & pwdata[`PAS_STATUS_BIT];
	assign swClear = writeControl & ~pwdata[`PAS_STATUS_BIT];

	// Control register
	always @(posedge clk)
	begin
		if (rst)
		begin
			sourceSelect <= 3'h0;
			pairAcState <= 2'h0;
			pairBdState <= 2'h0;
		end
		else if (writeControl)
		begin
			sourceSelect <= pwdata[`PAS_SRC_HI:`PAS_SRC_LO];
			pairAcState <= pwdata[`PAS_AC_HI:`PAS_AC_LO];
			pairBdState <= pwdata[`PAS_BD_HI:`PAS_BD_LO];
		end
	end

	// Sticky status; an event wins over a clear in the same cycle
	assign faultEntry = syncFault | swSet;
	assign restartClear = swClear | autoRestart;

	always @*
	begin
		next_shutdownStatus = shutdownStatus;
		if (faultEntry)
		begin
			next_shutdownStatus = 1'b1;
		end
		else if (restartClear)
		begin
			next_shutdownStatus = 1'b0;
		end
	end

	always @(posedge clk)
	begin
		if (rst)
		begin
			shutdownStatus <= 1'b0;
		end
		else if (clkEn)
		begin
			shutdownStatus <= next_shutdownStatus;
		end
	end

	assign shutActive = shutdownStatus | rawFault;

	// Shutdown level and drive of each pair; tri-state also drives out low
	assign pairAcTri = pairAcState[1];
	assign pairAcLevel = (pairAcState == `PAS_STATE_HIGH);
	assign pairBdTri = pairBdState[1];
	assign pairBdLevel = (pairBdState == `PAS_STATE_HIGH);

	// Output override; even pins are a and c, odd pins b and d
	always @*
	begin
		next_pwmOut = pwmIn;
		next_pwmOe = pwmEnable;
		for (i = 0; i < 4; i = i + 1)
		begin
			if (shutActive && pwmEnable[i] && (i % 2 == 0))
			begin
				next_pwmOut[i] = pairAcLevel;
				next_pwmOe[i] = ~pairAcTri;
			end
			else if (shutActive && pwmEnable[i])
			begin
				next_pwmOut[i] = pairBdLevel;
				next_pwmOe[i] = ~pairBdTri;
			end
		end
	end

	// Combinational so a fault forces the pins without a clock edge
	assign pwmOut = next_pwmOut;
	assign pwmOe = next_pwmOe;

	// Interrupt status: shutdown entry and auto-restart
	// Restart counts only when it really clears the status
	assign irqEvents = {autoRestart & shutdownStatus & ~faultEntry,
		faultEntry & ~shutdownStatus};
	assign irqClear = writeIrqStatus ? pwdata[`PAS_IRQ_WIDTH-1:0]
		: {`PAS_IRQ_WIDTH{1'b0}};

	// Set wins: an event in the clearing cycle stays pending
	always @*
	begin
		next_irqStatus = (irqStatus & ~irqClear) | irqEvents;
	end

	always @(posedge clk)
	begin
		if (rst)
		begin
			irqStatus <= {`PAS_IRQ_WIDTH{1'b0}};
		end
		else if (clkEn)
		begin
			irqStatus <= next_irqStatus;
		end
	end

	always @(posedge clk)
	begin
		if (rst)
		begin
			irqMask <= {`PAS_IRQ_WIDTH{1'b0}};
		end
		else if (clkEn && writeIrqMask)
		begin
			irqMask <= pwdata[`PAS_IRQ_WIDTH-1:0];
		end
	end

	assign irq = |(irqStatus & irqMask);

	assign controlRead = {shutdownStatus, sourceSelect, pairAcState,
		pairBdState};

	// Read multiplexer; unmapped and reserved words read zero
	always @*
	begin
		next_readData = 32'h00000000;
		case (paddr)
			`PAS_ADDR_CONTROL:
			begin
				next_readData = {24'h000000, controlRead};
			end
			`PAS_ADDR_IRQ_STATUS:
			begin
				next_readData = {30'h00000000, irqStatus};
			end
			`PAS_ADDR_IRQ_MASK:
			begin
				next_readData = {30'h00000000, irqMask};
			end
			`PAS_ADDR_RESTART:
			begin
				next_readData = 32'h00000000;
			end
			default:
			begin
				next_readData = 32'h00000000;
			end
		endcase
	end

	// Read data registered in the setup cycle, held through the access
	always @(posedge clk)
	begin
		if (rst)
		begin
			readData <= 32'h00000000;
		end
		else if (clkEn && apbRead && !penable)
		begin
			readData <= next_readData;
		end
	end

endmodule // pas_auto_shutdown
`default_nettype wire
